/* inc/tksr_regs.vh */
`ifndef TKSR_REGS_VH
`define TKSR_REGS_VH

`define TKSR_CLK_KHZ 100000
`define TKSR_BASE_MS 8
`define TKSR_PWRUP_MS 100
`define TKSR_WDOG_MS 125
`define TKSR_NACK_MS 30

// Bus address is arbitrary
`define TKSR_I2C_ADDR 7'h2A
// Identity byte value is arbitrary
`define TKSR_CHIP_ID 8'h5A

`define TKSR_A_CHIP 8'h00
`define TKSR_A_GSTAT 8'h02
`define TKSR_A_KSTAT 8'h03
`define TKSR_A_CAL 8'h04
`define TKSR_A_RST 8'h05
`define TKSR_A_IVAL 8'h06
`define TKSR_A_GUARD 8'h07
`define TKSR_A_MAXON 8'h08
`define TKSR_A_THR 8'h10
`define TKSR_A_AVG 8'h18
`define TKSR_A_GRP 8'h20
`define TKSR_A_DI 8'h28

`define TKSR_DEF_IVAL 8'h02
`define TKSR_DEF_GUARD 3'h7
`define TKSR_NO_GUARD 3'h7
`define TKSR_DEF_MAXON 8'hB4
`define TKSR_DEF_THR 8'h14
`define TKSR_DEF_AVG 8'h08
`define TKSR_DEF_GRP 2'h0
`define TKSR_DEF_DI 8'h04
`define TKSR_DI_MIN 8'h02
`define TKSR_LONG_AVG 8'h20
`define TKSR_SA_KEYS 7'h1F
`define TKSR_NKEYS 7

`endif

/* logic/tksr_touch_key_status_reporter.v */
`timescale 1ns/1ps
`include "tksr_regs.vh"

// Behaviour
// - Mode pin caught after reset: high gives standalone, low gives bus operation.
// - Standalone uses fixed settings and reports each key on its own line.
// - Standalone key 0 is guard and wins over other keys filtering in.
// - Standalone drives five open-drain detect lines; first one shows guard.
// - Bus operation drives no key lines; shared pins serve bus and change.
// - Seven keys in bus operation, four plus guard in standalone.
// - Base cycle of 8 ms; acquire every N base cycles per interval setting.
// - Host writes interval byte over the bus; 255 intervals selectable.
// - Calibrating, touched or integrating forces acquisition every base cycle.
// - Large averaging factor stretches an acquisition over an extra base cycle.
// - Up to three groups, at most one touched key in each.
// - A detecting group key blocks its group mates until it leaves detect.
// - Keys outside a group may detect alongside that group's keys.
// - Change line pulled low when status bytes change.
// - Change line released when host reads a status byte.
// - Status back to old value unread: change held until any read.
// - Change line pulled low 100 ms after any reset.
// - Host reads a status register showing each key's touch state.
// - Host configures threshold, group, integrator, interval, guard, max on-time.
// - Nonzero reset byte resets after 125 ms; bus NACKed first 30 ms.
// - Nonzero calibration byte recalibrates and clears key status and overflow.
// - Integrator needs two or more confirming samples; 0 and 1 act as 2.
module tksr_touch_key_status_reporter #(
	parameter BASE_CYC = `TKSR_BASE_MS * `TKSR_CLK_KHZ,
	parameter PWRUP_CYC = `TKSR_PWRUP_MS * `TKSR_CLK_KHZ,
	parameter NACK_CYC = `TKSR_NACK_MS * `TKSR_CLK_KHZ,
	parameter WDOG_CYC = `TKSR_WDOG_MS * `TKSR_CLK_KHZ
)(
	input wire ref_clk,
	input wire rstn,
	input wire mode_pin,
	input wire [6:0] key_touch_raw,
	input wire scl_in,
	input wire sda_in,
	output wire sda_guard_out,
	output reg sda_guard_oe,
	output wire scl_key3_out,
	output reg scl_key3_oe,
	output wire change_key4_out,
	output reg change_key4_oe,
	output wire key1_detect_out,
	output reg key1_detect_oe,
	output wire key2_detect_out,
	output reg key2_detect_oe,
	output reg [6:0] key_status
);
	localparam [23:0] BASE_LAST = BASE_CYC - 1;
	localparam [23:0] PWRUP_LAST = PWRUP_CYC - 1;
	localparam [23:0] NACK_LAST = NACK_CYC - 1;
	localparam [23:0] WDOG_LAST = WDOG_CYC - 1;
	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_ADDR = 3'h1;
	localparam [2:0] S_ACKA = 3'h2;
	localparam [2:0] S_WRITE = 3'h3;
	localparam [2:0] S_ACKW = 3'h4;
	localparam [2:0] S_READ = 3'h5;
	localparam [2:0] S_RACK = 3'h6;
	localparam [6:0] SA_KEYS = `TKSR_SA_KEYS;

	function in_blk;
		input [7:0] a;
		input [7:0] base;
		begin
			in_blk = (a[7:3] == base[7:3]) && (a[2:0] != 3'h7);
		end
	endfunction

	function [7:0] di_eff;
		input [7:0] di;
		begin
			di_eff = (di < `TKSR_DI_MIN) ? `TKSR_DI_MIN : di;
		end
	endfunction

	// Soft reset reuses the async path; the pulse comes from one flop, so it cannot glitch
	reg soft_rst_reg;
	wire core_rstn = rstn & ~soft_rst_reg;
	reg wd_run_reg;
	reg [23:0] wd_cnt_reg;
	reg wr_p_reg;
	reg [7:0] wr_a_reg, wr_d_reg;
	reg rd_p_reg;
	reg [7:0] rd_a_reg;
	wire wd_start = wr_p_reg && (wr_a_reg == `TKSR_A_RST) && (wr_d_reg != 8'h00);

	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wd_run_reg <= 1'b0;
			wd_cnt_reg <= 24'h00_0000;
			soft_rst_reg <= 1'b0;
		end else begin
			soft_rst_reg <= 1'b0;
			if (wd_run_reg) begin
				wd_cnt_reg <= wd_cnt_reg + 24'h00_0001;
				if (wd_cnt_reg == WDOG_LAST) begin
					wd_run_reg <= 1'b0;
					soft_rst_reg <= 1'b1;
				end
			end else if (wd_start) begin
				wd_run_reg <= 1'b1;
				wd_cnt_reg <= 24'h00_0000;
			end
		end
	end

	reg mode_s1, mode_s2, sa_reg, comms_reg;
	reg [1:0] mode_wait_reg;
	reg [6:0] raw_s1, raw_s2;
	reg scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
	reg [23:0] pu_cnt_reg;
	reg pu_done_reg, nack_reg, pu_evt_reg;

	always @(posedge ref_clk or negedge core_rstn) begin
		if (!core_rstn) begin
			mode_s1 <= 1'b0;
			mode_s2 <= 1'b0;
			mode_wait_reg <= 2'h0;
			sa_reg <= 1'b0;
			comms_reg <= 1'b0;
			raw_s1 <= 7'h00;
			raw_s2 <= 7'h00;
			{scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d} <= 6'h3F;
			pu_cnt_reg <= 24'h00_0000;
			pu_done_reg <= 1'b0;
			nack_reg <= 1'b1;
			pu_evt_reg <= 1'b0;
		end else begin
			mode_s1 <= mode_pin;
			mode_s2 <= mode_s1;
			raw_s1 <= key_touch_raw;
			raw_s2 <= raw_s1;
			{scl_s1, scl_s2, scl_d} <= {scl_in, scl_s1, scl_s2};
			{sda_s1, sda_s2, sda_d} <= {sda_in, sda_s1, sda_s2};
			if (mode_wait_reg != 2'h3) begin
				mode_wait_reg <= mode_wait_reg + 2'h1;
				if (mode_wait_reg == 2'h2) begin
					sa_reg <= mode_s2;
					comms_reg <= ~mode_s2;
				end
			end
			pu_evt_reg <= 1'b0;
			if (!pu_done_reg) begin
				pu_cnt_reg <= pu_cnt_reg + 24'h00_0001;
				if (pu_cnt_reg == NACK_LAST)
					nack_reg <= 1'b0;
				if (pu_cnt_reg == PWRUP_LAST) begin
					pu_done_reg <= 1'b1;
					pu_evt_reg <= 1'b1;
				end
			end
		end
	end

	wire scl_rise = scl_s2 & ~scl_d;
	wire scl_fall = ~scl_s2 & scl_d;
	wire i2c_start = scl_s2 & scl_d & sda_d & ~sda_s2;
	wire i2c_stop = scl_s2 & scl_d & ~sda_d & sda_s2;

	reg [7:0] ival_reg, maxon_reg;
	reg [2:0] guard_reg;
	reg [55:0] thr_reg, avg_reg, di_reg, cnt_reg;
	reg [13:0] grp_reg;
	reg [6:0] det_reg;
	reg cal_reg, ovf_reg;
	reg [7:0] rd_data;
	reg [7:0] sh_reg, ptr_reg;
	wire [7:0] rd_a_cur = ptr_reg;
	integer i;
	integer j;

	always @* begin
		rd_data = 8'h00;
		if (rd_a_cur == `TKSR_A_CHIP)
			rd_data = `TKSR_CHIP_ID;
		else if (rd_a_cur == `TKSR_A_GSTAT)
			rd_data = {cal_reg, ovf_reg, 6'h00};
		else if (rd_a_cur == `TKSR_A_KSTAT)
			rd_data = {1'b0, det_reg};
		else if (rd_a_cur == `TKSR_A_IVAL)
			rd_data = ival_reg;
		else if (rd_a_cur == `TKSR_A_GUARD)
			rd_data = {5'h00, guard_reg};
		else if (rd_a_cur == `TKSR_A_MAXON)
			rd_data = maxon_reg;
		else if (in_blk(rd_a_cur, `TKSR_A_THR))
			rd_data = thr_reg[rd_a_cur[2:0]*8 +: 8];
		else if (in_blk(rd_a_cur, `TKSR_A_AVG))
			rd_data = avg_reg[rd_a_cur[2:0]*8 +: 8];
		else if (in_blk(rd_a_cur, `TKSR_A_GRP))
			rd_data = {6'h00, grp_reg[rd_a_cur[2:0]*2 +: 2]};
		else if (in_blk(rd_a_cur, `TKSR_A_DI))
			rd_data = di_reg[rd_a_cur[2:0]*8 +: 8];
	end

	reg [2:0] st_reg;
	reg [3:0] bit_cnt_reg;
	reg rw_reg, first_reg, sda_drv_reg;

	always @(posedge ref_clk or negedge core_rstn) begin
		if (!core_rstn) begin
			st_reg <= S_IDLE;
			bit_cnt_reg <= 4'h0;
			sh_reg <= 8'h00;
			ptr_reg <= 8'h00;
			rw_reg <= 1'b0;
			first_reg <= 1'b0;
			sda_drv_reg <= 1'b0;
			wr_p_reg <= 1'b0;
			wr_a_reg <= 8'h00;
			wr_d_reg <= 8'h00;
			rd_p_reg <= 1'b0;
			rd_a_reg <= 8'h00;
		end else begin
			wr_p_reg <= 1'b0;
			rd_p_reg <= 1'b0;
			if (!comms_reg) begin
				st_reg <= S_IDLE;
				sda_drv_reg <= 1'b0;
			end else if (i2c_start) begin
				st_reg <= S_ADDR;
				bit_cnt_reg <= 4'h0;
				sda_drv_reg <= 1'b0;
			end else if (i2c_stop) begin
				st_reg <= S_IDLE;
				sda_drv_reg <= 1'b0;
			end else if (scl_rise) begin
				case (st_reg)
				S_ADDR, S_WRITE: begin
					sh_reg <= {sh_reg[6:0], sda_s2};
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
				end
				S_READ: bit_cnt_reg <= bit_cnt_reg + 4'h1;
				S_RACK: if (sda_s2)
					st_reg <= S_IDLE;
				default: ;
				endcase
			end else if (scl_fall) begin
				case (st_reg)
				S_ADDR: if (bit_cnt_reg == 4'h8) begin
					if ((sh_reg[7:1] == `TKSR_I2C_ADDR) && !nack_reg) begin
						sda_drv_reg <= 1'b1;
						rw_reg <= sh_reg[0];
						st_reg <= S_ACKA;
					end else
						st_reg <= S_IDLE;
				end
				S_ACKA: begin
					bit_cnt_reg <= 4'h0;
					first_reg <= 1'b1;
					if (rw_reg) begin
						sh_reg <= rd_data;
						sda_drv_reg <= ~rd_data[7];
						rd_p_reg <= 1'b1;
						rd_a_reg <= ptr_reg;
						st_reg <= S_READ;
					end else begin
						sda_drv_reg <= 1'b0;
						st_reg <= S_WRITE;
					end
				end
				S_WRITE: if (bit_cnt_reg == 4'h8) begin
					sda_drv_reg <= 1'b1;
					bit_cnt_reg <= 4'h0;
					st_reg <= S_ACKW;
					first_reg <= 1'b0;
					if (first_reg)
						ptr_reg <= sh_reg;
					else begin
						wr_p_reg <= 1'b1;
						wr_a_reg <= ptr_reg;
						wr_d_reg <= sh_reg;
						ptr_reg <= ptr_reg + 8'h01;
					end
				end
				S_ACKW: begin
					sda_drv_reg <= 1'b0;
					st_reg <= S_WRITE;
				end
				S_READ: if (bit_cnt_reg == 4'h8) begin
					sda_drv_reg <= 1'b0;
					ptr_reg <= ptr_reg + 8'h01;
					st_reg <= S_RACK;
				end else begin
					sda_drv_reg <= ~sh_reg[6];
					sh_reg <= {sh_reg[6:0], 1'b0};
				end
				S_RACK: begin
					bit_cnt_reg <= 4'h0;
					sh_reg <= rd_data;
					sda_drv_reg <= ~rd_data[7];
					rd_p_reg <= 1'b1;
					rd_a_reg <= ptr_reg;
					st_reg <= S_READ;
				end
				default: st_reg <= S_IDLE;
				endcase
			end
		end
	end

	wire cal_req = wr_p_reg && (wr_a_reg == `TKSR_A_CAL) && (wr_d_reg != 8'h00);

	always @(posedge ref_clk or negedge core_rstn) begin
		if (!core_rstn) begin
			ival_reg <= `TKSR_DEF_IVAL;
			guard_reg <= `TKSR_DEF_GUARD;
			maxon_reg <= `TKSR_DEF_MAXON;
			thr_reg <= {`TKSR_NKEYS{`TKSR_DEF_THR}};
			avg_reg <= {`TKSR_NKEYS{`TKSR_DEF_AVG}};
			grp_reg <= {`TKSR_NKEYS{`TKSR_DEF_GRP}};
			di_reg <= {`TKSR_NKEYS{`TKSR_DEF_DI}};
		end else if (wr_p_reg) begin
			if (wr_a_reg == `TKSR_A_IVAL)
				ival_reg <= wr_d_reg;
			if (wr_a_reg == `TKSR_A_GUARD)
				guard_reg <= wr_d_reg[2:0];
			if (wr_a_reg == `TKSR_A_MAXON)
				maxon_reg <= wr_d_reg;
			if (in_blk(wr_a_reg, `TKSR_A_THR))
				thr_reg[wr_a_reg[2:0]*8 +: 8] <= wr_d_reg;
			if (in_blk(wr_a_reg, `TKSR_A_AVG))
				avg_reg[wr_a_reg[2:0]*8 +: 8] <= wr_d_reg;
			if (in_blk(wr_a_reg, `TKSR_A_GRP))
				grp_reg[wr_a_reg[2:0]*2 +: 2] <= wr_d_reg[1:0];
			if (in_blk(wr_a_reg, `TKSR_A_DI))
				di_reg[wr_a_reg[2:0]*8 +: 8] <= wr_d_reg;
		end
	end

	// Effective settings: standalone ignores the programmed values entirely
	reg [6:0] en_eff;
	reg [55:0] di_use;
	reg [13:0] grp_use;
	reg [2:0] guard_use;
	reg stretch_need;
	always @* begin
		guard_use = sa_reg ? 3'h0 : guard_reg;
		stretch_need = 1'b0;
		for (j = 0; j < `TKSR_NKEYS; j = j + 1) begin
			en_eff[j] = sa_reg ? SA_KEYS[j] : (avg_reg[j*8 +: 8] != 8'h00);
			di_use[j*8 +: 8] = di_eff(sa_reg ? `TKSR_DEF_DI : di_reg[j*8 +: 8]);
			grp_use[j*2 +: 2] = sa_reg ? 2'h0 : grp_reg[j*2 +: 2];
			if (!sa_reg && en_eff[j] && avg_reg[j*8 +: 8] >= `TKSR_LONG_AVG)
				stretch_need = 1'b1;
		end
	end

	reg [23:0] base_cnt_reg;
	reg [7:0] ival_cnt_reg;
	reg str_ph_reg, acq_p_reg, ovf_set;
	wire fast = cal_reg | (|det_reg) | (|cnt_reg);
	wire [7:0] ival_eff = (sa_reg | fast | (ival_reg == 8'h00)) ? 8'h01 : ival_reg;
	wire base_tick = (base_cnt_reg == BASE_LAST);

	always @(posedge ref_clk or negedge core_rstn) begin
		if (!core_rstn) begin
			base_cnt_reg <= 24'h00_0000;
			ival_cnt_reg <= 8'h00;
			str_ph_reg <= 1'b0;
			acq_p_reg <= 1'b0;
			ovf_set <= 1'b0;
		end else begin
			acq_p_reg <= 1'b0;
			ovf_set <= 1'b0;
			base_cnt_reg <= base_tick ? 24'h00_0000 : base_cnt_reg + 24'h00_0001;
			if (base_tick && (sa_reg | comms_reg)) begin
				if (str_ph_reg) begin
					str_ph_reg <= 1'b0;
					acq_p_reg <= 1'b1;
				end else if (ival_cnt_reg + 8'h01 >= ival_eff) begin
					ival_cnt_reg <= 8'h00;
					if (stretch_need) begin
						str_ph_reg <= 1'b1;
						ovf_set <= 1'b1;
					end else
						acq_p_reg <= 1'b1;
				end else
					ival_cnt_reg <= ival_cnt_reg + 8'h01;
			end
		end
	end

	// Exits are resolved before entries so a freed group can be retaken in the same cycle
	reg [6:0] det_n, cand;
	reg [55:0] cnt_n;
	reg [3:0] grp_busy;
	reg [7:0] c1;
	reg guard_filt;
	always @* begin
		det_n = det_reg;
		cnt_n = cnt_reg;
		cand = 7'h00;
		grp_busy = 4'h0;
		c1 = 8'h00;
		guard_filt = (guard_use != `TKSR_NO_GUARD) && raw_s2[guard_use] &&
			!det_reg[guard_use] && en_eff[guard_use];
		for (i = 0; i < `TKSR_NKEYS; i = i + 1) begin
			c1 = cnt_reg[i*8 +: 8] + 8'h01;
			if (!en_eff[i]) begin
				det_n[i] = 1'b0;
				cnt_n[i*8 +: 8] = 8'h00;
			end else if (det_reg[i]) begin
				cnt_n[i*8 +: 8] = raw_s2[i] ? 8'h00 : c1;
				if (!raw_s2[i] && c1 >= di_use[i*8 +: 8]) begin
					det_n[i] = 1'b0;
					cnt_n[i*8 +: 8] = 8'h00;
				end
			end else if (!raw_s2[i] || (guard_filt && guard_use != i)) begin
				cnt_n[i*8 +: 8] = 8'h00;
			end else if (c1 >= di_use[i*8 +: 8]) begin
				cand[i] = 1'b1;
			end else
				cnt_n[i*8 +: 8] = c1;
		end
		for (i = 0; i < `TKSR_NKEYS; i = i + 1)
			if (det_n[i])
				grp_busy[grp_use[i*2 +: 2]] = 1'b1;
		for (i = 0; i < `TKSR_NKEYS; i = i + 1)
			if (cand[i] && (grp_use[i*2 +: 2] == 2'h0 || !grp_busy[grp_use[i*2 +: 2]])) begin
				det_n[i] = 1'b1;
				cnt_n[i*8 +: 8] = 8'h00;
				grp_busy[grp_use[i*2 +: 2]] = 1'b1;
			end
	end

	reg chg_reg;
	reg [8:0] prev_stat_reg, snap_reg;
	wire [8:0] stat = {cal_reg, ovf_reg, det_reg};
	wire rd_stat = rd_p_reg && (rd_a_reg == `TKSR_A_GSTAT || rd_a_reg == `TKSR_A_KSTAT);

	always @(posedge ref_clk or negedge core_rstn) begin
		if (!core_rstn) begin
			det_reg <= 7'h00;
			cnt_reg <= 56'h00_0000_0000_0000;
			cal_reg <= 1'b1;
			ovf_reg <= 1'b0;
			chg_reg <= 1'b0;
			prev_stat_reg <= 9'h000;
			snap_reg <= 9'h000;
		end else begin
			if (cal_req) begin
				det_reg <= 7'h00;
				cnt_reg <= 56'h00_0000_0000_0000;
			end else if (acq_p_reg) begin
				det_reg <= det_n;
				cnt_reg <= cnt_n;
			end
			if (cal_req)
				cal_reg <= 1'b1;
			else if (acq_p_reg)
				cal_reg <= 1'b0;
			if (ovf_set)
				ovf_reg <= 1'b1;
			else if (cal_req)
				ovf_reg <= 1'b0;
			prev_stat_reg <= stat;
			if (rd_stat)
				snap_reg <= stat;
			// A change in the same cycle as a clearing read keeps the line low
			if (comms_reg && pu_done_reg && (stat != prev_stat_reg))
				chg_reg <= 1'b1;
			else if (comms_reg && pu_evt_reg)
				chg_reg <= 1'b1;
			else if (rd_stat)
				chg_reg <= 1'b0;
			else if (rd_p_reg && stat == snap_reg)
				chg_reg <= 1'b0;
		end
	end

	reg pin_low_reg;
	assign sda_guard_out = pin_low_reg;
	assign scl_key3_out = pin_low_reg;
	assign change_key4_out = pin_low_reg;
	assign key1_detect_out = pin_low_reg;
	assign key2_detect_out = pin_low_reg;

	always @(posedge ref_clk or negedge core_rstn) begin
		if (!core_rstn) begin
			pin_low_reg <= 1'b0;
			sda_guard_oe <= 1'b0;
			scl_key3_oe <= 1'b0;
			change_key4_oe <= 1'b0;
			key1_detect_oe <= 1'b0;
			key2_detect_oe <= 1'b0;
			key_status <= 7'h00;
		end else begin
			pin_low_reg <= 1'b0;
			sda_guard_oe <= sa_reg ? det_reg[0] : sda_drv_reg;
			scl_key3_oe <= sa_reg & det_reg[3];
			change_key4_oe <= sa_reg ? det_reg[4] : chg_reg;
			key1_detect_oe <= sa_reg & det_reg[1];
			key2_detect_oe <= sa_reg & det_reg[2];
			key_status <= det_reg;
		end
	end
endmodule // tksr_touch_key_status_reporter

/* bench/tksr_props.sv */
`timescale 1ns/1ps
module tksr_props #(
	parameter PWRUP_CYC = 200,
	parameter NACK_CYC = 60
)(
	input wire ref_clk,
	input wire rstn,
	input wire mode_pin,
	input wire [6:0] key_touch_raw,
	input wire sda_guard_out,
	input wire sda_guard_oe,
	input wire scl_key3_out,
	input wire scl_key3_oe,
	input wire change_key4_out,
	input wire change_key4_oe,
	input wire key1_detect_out,
	input wire key1_detect_oe,
	input wire key2_detect_out,
	input wire key2_detect_oe,
	input wire [6:0] key_status
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// Saturates so a later soft reset cannot be mistaken for a power-up
	int since_rst_reg;
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			since_rst_reg <= 0;
		else if (since_rst_reg < PWRUP_CYC + 8)
			since_rst_reg <= since_rst_reg + 1;
	end
	AST_OD_LOW: assert property (!(sda_guard_out | scl_key3_out | change_key4_out |
		key1_detect_out | key2_detect_out)) else $error("open-drain pin driven high");
	AST_COMMS_NO_LED: assert property (!mode_pin |->
		!(key1_detect_oe | key2_detect_oe | scl_key3_oe)) else $error("key line in comms");
	AST_SA_LINES: assert property (((mode_pin && $stable(key_status)) [*3]) |->
		{change_key4_oe, scl_key3_oe, key2_detect_oe, key1_detect_oe, sda_guard_oe}
		== key_status[4:0]) else $error("standalone lines differ from status");
	AST_SA_FIVE_KEYS: assert property (mode_pin |-> key_status[6:5] == 2'h0)
		else $error("standalone key above four detected");
	AST_CHANGE_ON_STATUS: assert property ((!mode_pin && key_status != 7'h00 &&
		key_status != $past(key_status)) |-> ##[1:4] change_key4_oe)
		else $error("change line missed a status change");
	AST_STATUS_NEEDS_RAW: assert property ($rose(key_status[1]) |->
		$past(key_touch_raw[1], 2) || $past(key_touch_raw[1], 3) || $past(key_touch_raw[1], 4))
		else $error("detect without touch");
	AST_PWRUP_CHANGE: assert property ((since_rst_reg == PWRUP_CYC + 6 && !mode_pin) |->
		change_key4_oe) else $error("change line not low after power-up");
	AST_NACK_WINDOW: assert property ((since_rst_reg < NACK_CYC && !mode_pin) |->
		!sda_guard_oe) else $error("bus answered during start-up");
endmodule // tksr_props

/* bench/tksr_host.sv */
`timescale 1ns/1ps
`include "tksr_regs.vh"
module tksr_host (
	input wire ref_clk,
	input wire sda_line,
	output logic scl_low,
	output logic sda_low,
	output logic rd_stb,
	output logic [7:0] rd_byte
);
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
		rd_stb = 1'b0;
		rd_byte = 8'h00;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// Bit of 16 clocks; data moves only while clock is low
	task automatic bitx(input logic b, output logic r);
		sda_low <= !b;
		tick(4);
		scl_low <= 1'b0;
		tick(4);
		r = sda_line;
		tick(4);
		scl_low <= 1'b1;
		tick(4);
	endtask
	task automatic start();
		sda_low <= 1'b0;
		tick(4);
		scl_low <= 1'b0;
		tick(4);
		sda_low <= 1'b1;
		tick(4);
		scl_low <= 1'b1;
		tick(4);
	endtask
	task automatic stop();
		sda_low <= 1'b1;
		tick(4);
		scl_low <= 1'b0;
		tick(4);
		sda_low <= 1'b0;
		tick(8);
	endtask
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
		output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], r);
			q[i] = r;
		end
		bitx(last, r);
		ack = !r;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
		logic [7:0] q;
		logic k;
		start();
		xfer({`TKSR_I2C_ADDR, 1'b0}, 1'b1, q, ok);
		xfer(a, 1'b1, q, k);
		xfer(d, 1'b1, q, k);
		stop();
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		logic k;
		start();
		xfer({`TKSR_I2C_ADDR, 1'b0}, 1'b1, q, k);
		xfer(a, 1'b1, q, k);
		start();
		xfer({`TKSR_I2C_ADDR, 1'b1}, 1'b1, q, k);
		xfer(8'hFF, 1'b1, q, k);
		rd_byte <= q;
		rd_stb <= 1'b1;
		tick(1);
		rd_stb <= 1'b0;
		stop();
	endtask
endmodule // tksr_host

/* bench/tksr_touch_key_status_reporter_bench.sv */
`timescale 1ns/1ps
`include "tksr_regs.vh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
	$display("[ERR] %0t got %h expected %h", $time, (a), (e)); end end
module tksr_touch_key_status_reporter_bench;
	localparam BC = 50;
	localparam PW = 200;
	localparam WD = 100;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic mode_pin = 1'b0;
	logic [6:0] key_touch_raw = 7'h00;
	wire scl_low, sda_low, rd_stb;
	wire [7:0] rd_byte;
	wire sda_guard_out, sda_guard_oe, scl_key3_out, scl_key3_oe;
	wire change_key4_out, change_key4_oe;
	wire key1_detect_out, key1_detect_oe, key2_detect_out, key2_detect_oe;
	wire [6:0] key_status;
	wire sda_in = !(sda_low || sda_guard_oe);
	wire scl_in = !(scl_low || scl_key3_oe);
	int bad_count = 0;
	int check_count = 0;
	logic [7:0] exp_q[$];
	logic [7:0] e_v;
	logic [7:0] v;
	logic [7:0] iv;
	logic [31:0] seed = 32'h0dd5_d3ec;
	logic ok;
	always #5 ref_clk = ~ref_clk;
	tksr_touch_key_status_reporter #(.BASE_CYC(BC), .PWRUP_CYC(PW), .NACK_CYC(180),
		.WDOG_CYC(WD)) DUT (.ref_clk(ref_clk), .rstn(rstn), .mode_pin(mode_pin),
		.key_touch_raw(key_touch_raw), .scl_in(scl_in), .sda_in(sda_in),
		.sda_guard_out(sda_guard_out), .sda_guard_oe(sda_guard_oe),
		.scl_key3_out(scl_key3_out), .scl_key3_oe(scl_key3_oe),
		.change_key4_out(change_key4_out), .change_key4_oe(change_key4_oe),
		.key1_detect_out(key1_detect_out), .key1_detect_oe(key1_detect_oe),
		.key2_detect_out(key2_detect_out), .key2_detect_oe(key2_detect_oe),
		.key_status(key_status));
	tksr_host u_host (.ref_clk(ref_clk), .sda_line(sda_in), .scl_low(scl_low),
		.sda_low(sda_low), .rd_stb(rd_stb), .rd_byte(rd_byte));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic do_reset(input logic m);
		rstn <= 1'b0;
		mode_pin <= m;
		cyc(5);
		rstn <= 1'b1;
	endtask
	// Bounded wait, then a few edges so derived outputs have landed
	task automatic wait_key(input int k, input logic val);
		int n;
		n = 0;
		while (key_status[k] !== val && n < 40 * BC) begin
			cyc(1);
			n++;
		end
		cyc(4);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		u_host.rd(a, v);
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		if (rd_stb === 1'b1) begin
			e_v = exp_q.pop_front();
			`CHK(rd_byte, e_v)
		end
	end
	initial begin
		cyc(60000);
		bad_count++;
		give_verdict();
	end
	initial begin
		do_reset(1'b1);
		u_host.wr(`TKSR_A_IVAL, 8'h05, ok);
		`CHK(ok, 1'b0)
		key_touch_raw <= 7'h25;
		wait_key(0, 1'b1);
		`CHK(key_status[2], 1'b0)
		`CHK(sda_guard_oe, 1'b1)
		wait_key(2, 1'b1);
		`CHK(key2_detect_oe, 1'b1)
		`CHK(key_status[5], 1'b0)
		key_touch_raw <= 7'h00;
		do_reset(1'b0);
		// Address byte ends inside the start-up window, so it must be refused
		u_host.wr(`TKSR_A_IVAL, 8'h05, ok);
		`CHK(ok, 1'b0)
		cyc(PW + 8);
		`CHK(change_key4_oe, 1'b1)
		rd_chk(`TKSR_A_KSTAT, 8'h00);
		`CHK(change_key4_oe, 1'b0)
		rd_chk(`TKSR_A_CHIP, `TKSR_CHIP_ID);
		seed = xs(seed);
		// Interval kept at or below 32 so detection lands inside the wait_key bound
		iv = 8'(seed[4:0]) + 8'h01;
		u_host.wr(`TKSR_A_IVAL, iv, ok);
		`CHK(ok, 1'b1)
		rd_chk(`TKSR_A_IVAL, iv);
		u_host.wr(`TKSR_A_THR + 8'h03, seed[15:8], ok);
		rd_chk(`TKSR_A_THR + 8'h03, seed[15:8]);
		u_host.wr(`TKSR_A_GRP + 8'h01, 8'h01, ok);
		u_host.wr(`TKSR_A_GRP + 8'h02, 8'h01, ok);
		u_host.wr(`TKSR_A_DI + 8'h01, 8'h00, ok);
		key_touch_raw <= 7'h02;
		wait_key(1, 1'b1);
		`CHK(key_status[1], 1'b1)
		`CHK(change_key4_oe, 1'b1)
		rd_chk(`TKSR_A_KSTAT, 8'h02);
		key_touch_raw <= 7'h0E;
		wait_key(3, 1'b1);
		`CHK(key_status, 7'h0A)
		cyc(10 * BC);
		`CHK(key_status[2], 1'b0)
		key_touch_raw <= 7'h0C;
		wait_key(2, 1'b1);
		`CHK(key_status, 7'h0C)
		rd_chk(`TKSR_A_KSTAT, 8'h0C);
		key_touch_raw <= 7'h1C;
		wait_key(4, 1'b1);
		key_touch_raw <= 7'h0C;
		wait_key(4, 1'b0);
		`CHK(change_key4_oe, 1'b1)
		rd_chk(`TKSR_A_CHIP, `TKSR_CHIP_ID);
		`CHK(change_key4_oe, 1'b0)
		// Unused key switched off through a zero averaging factor
		u_host.wr(`TKSR_A_AVG + 8'h06, 8'h00, ok);
		key_touch_raw <= 7'h4C;
		cyc(20 * BC);
		`CHK(key_status[6], 1'b0)
		u_host.wr(`TKSR_A_AVG, `TKSR_LONG_AVG, ok);
		cyc(8 * BC);
		rd_chk(`TKSR_A_GSTAT, 8'h40);
		u_host.wr(`TKSR_A_CAL, 8'h01, ok);
		`CHK(key_status, 7'h00)
		wait_key(2, 1'b1);
		u_host.wr(`TKSR_A_RST, 8'h01, ok);
		cyc(WD + 5);
		`CHK(key_status, 7'h00)
		key_touch_raw <= 7'h00;
		cyc(PW + 8);
		`CHK(change_key4_oe, 1'b1)
		rd_chk(`TKSR_A_IVAL, `TKSR_DEF_IVAL);
		cyc(20);
		give_verdict();
	end
endmodule // tksr_touch_key_status_reporter_bench
bind tksr_touch_key_status_reporter tksr_props #(.PWRUP_CYC(PWRUP_CYC),
	.NACK_CYC(NACK_CYC)) u_props (.ref_clk(ref_clk), .rstn(rstn), .mode_pin(mode_pin),
	.key_touch_raw(key_touch_raw), .sda_guard_out(sda_guard_out),
	.sda_guard_oe(sda_guard_oe), .scl_key3_out(scl_key3_out), .scl_key3_oe(scl_key3_oe),
	.change_key4_out(change_key4_out), .change_key4_oe(change_key4_oe),
	.key1_detect_out(key1_detect_out), .key1_detect_oe(key1_detect_oe),
	.key2_detect_out(key2_detect_out), .key2_detect_oe(key2_detect_oe),
	.key_status(key_status));
